// ==== hspc_pkg.sv ====
/*
  constants, register map and carrier types of the pulse counter.
  assumes one 125 MHz clock and a byte-addressed plain register port.
*/
// Summary of operation
// - count only from four dedicated inputs, 20 kHz
// - never fed from expansion module inputs
// - eight mode values 0-7; modes 6-7 count as modes 2-3
// - running count is 32-bit signed
// - counting logic runs independent of processor
// - raise handler requests on presets and limits
// - drive output bits directly from count events
// - file presents 36 bit, word, long sub-elements
// - low preset and underflow only modes 2-7
// - reached and down flags only modes 2-7
// - count, presets, patterns writable while running
// - output mask, mode, handler file read-only
// - missed flag set by device, software clears
// - values may change while software reads
// - acts as programmable limit switch
// - counting enable holds count, resets cleared
// - load-settings rise checks, loads, keeps counts
// - fault codes 1 file,2 mode,3 high,4 over
// - handler requested only while handler enable set
package hspc_pkg;

  localparam int CLK_HZ       = 125_000_000;
  localparam int MAX_RATE_HZ  = 20_000;
  localparam int NUM_PINS     = 4;
  localparam int NUM_SUBELEMS = 36;

  // register byte addresses, one four-byte word apart
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_PFN   = 8'h0C;
  localparam logic [7:0] ADDR_MODE  = 8'h10;
  localparam logic [7:0] ADDR_ACC   = 8'h14;
  localparam logic [7:0] ADDR_HIP   = 8'h18;
  localparam logic [7:0] ADDR_LOP   = 8'h1C;
  localparam logic [7:0] ADDR_OVF   = 8'h20;
  localparam logic [7:0] ADDR_UNF   = 8'h24;
  localparam logic [7:0] ADDR_OMB   = 8'h28;
  localparam logic [7:0] ADDR_HPO   = 8'h2C;
  localparam logic [7:0] ADDR_LPO   = 8'h30;

  // control register bits
  localparam int C_FE = 0;
  localparam int C_CE = 1;
  localparam int C_SP = 2;
  localparam int C_UIE = 3;
  localparam int C_LPM = 4;
  localparam int C_HPM = 5;
  localparam int C_UFM = 6;
  localparam int C_OFM = 7;
  localparam int C_AS = 8;

  // status register bits, 8 and up are software writable
  localparam int S_UIX = 0;
  localparam int S_UIP = 1;
  localparam int S_ED = 2;
  localparam int S_LPR = 3;
  localparam int S_HPR = 4;
  localparam int S_DIR = 5;
  localparam int S_CD = 6;
  localparam int S_CU = 7;
  localparam int S_UIL = 8;
  localparam int S_LPI = 9;
  localparam int S_HPI = 10;
  localparam int S_UFI = 11;
  localparam int S_OFI = 12;
  localparam int S_UF = 13;
  localparam int S_OF = 14;
  localparam int S_MD = 15;

  localparam logic [15:0] FLT_NONE = 16'h0000;
  localparam logic [15:0] FLT_FILE = 16'h0001;
  localparam logic [15:0] FLT_MODE = 16'h0002;
  localparam logic [15:0] FLT_HIGH = 16'h0003;
  localparam logic [15:0] FLT_OVF  = 16'h0004;

  localparam logic [15:0] PFN_MIN        = 16'h0003;
  localparam logic [15:0] PFN_MAX        = 16'h00FF;
  localparam logic [15:0] MODE_MAX       = 16'h0007;
  localparam logic [15:0] MODE_LOW_FIRST = 16'h0002;

  localparam logic signed [31:0] RST_HIP = 32'sh0000_0000;
  localparam logic signed [31:0] RST_LOP = 32'sh0000_0000;
  localparam logic signed [31:0] RST_OVF = 32'sh7FFF_FFFF;
  localparam logic signed [31:0] RST_UNF = 32'sh8000_0001;

  // stored program settings, loaded on run entry or load-settings
  typedef struct packed {
    logic        autoStart;
    logic [15:0] handlerFile;
    logic [15:0] mode;
    logic [15:0] outMask;
  } hspc_cfg_t;

  typedef struct packed {
    logic up;
    logic down;
    logic zero;
    logic hold;
  } hspc_step_t;

endpackage

// ==== hspc_decoder.sv ====
/*
  input synchroniser and count decoder for the four embedded pins.
  assumes pins are asynchronous and slower than clk by far.
*/
`timescale 1ns/1ps
module hspc_decoder
#(
  parameter int PINS = hspc_pkg::NUM_PINS
)
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // embedded pins and active mode
  input  wire logic [PINS-1:0]    pinIn,
  input  wire logic [2:0]         mode,
  // decoded step, registered
  output hspc_pkg::hspc_step_t    step
);

  logic [PINS-1:0] s1Q;
  logic [PINS-1:0] s2Q;
  logic [PINS-1:0] s3Q;
  logic [PINS-1:0] rise;
  hspc_pkg::hspc_step_t stepD;

  // four pins only; less cannot serve reset and hold
  if (PINS != 4 || hspc_pkg::CLK_HZ < 4 * hspc_pkg::MAX_RATE_HZ)
  begin : g_bad
    $error("pin count or clock rate unsupported");
  end

  // only dedicated pins reach here, no expansion path
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1Q <= '0;
      s2Q <= '0;
      s3Q <= '0;
    end
    else
    begin
      s1Q <= pinIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
    end
  end

  assign rise = s2Q & ~s3Q;

  // odd modes add reset on pin 2 and hold on pin 3
  always_comb
  begin
    stepD      = '0;
    stepD.hold = mode[0] & s2Q[3];
    stepD.zero = mode[0] & rise[2];
    case (mode[2:1])
      2'b00:
      begin
        stepD.up = rise[0];
      end
      2'b01:
      begin
        stepD.up   = rise[0] & ~s2Q[1];
        stepD.down = rise[0] & s2Q[1];
      end
      2'b10:
      begin
        stepD.up   = rise[0] & ~rise[1];
        stepD.down = rise[1] & ~rise[0];
      end
      2'b11:
      begin
        stepD.up   = rise[0] & ~s2Q[1];
        stepD.down = rise[0] & s2Q[1];
      end
      default:
      begin
        stepD.up = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      step <= '0;
    else
      step <= stepD;
  end

  AST_ONE_WAY: assert property (@(posedge clk) disable iff (rst)
    step.up |-> !step.down && $past(s2Q[0]) == 1'b1)
    else $error("step not one way or not from pin 0 edge");

endmodule

// ==== hspc_top.sv ====
/*
  pulse counter core: accumulator, presets, limit outputs, handler
  requests and register file. assumes a plain register port on clk
  and stored settings presented steadily on cfgIn.
*/
`timescale 1ns/1ps
module hspc_top
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdata,
  // embedded count pins
  input  wire logic [3:0]           countPins,
  // controller state and stored settings
  input  wire logic                 controllerRun,
  input  wire hspc_pkg::hspc_cfg_t  cfgIn,
  // handler request
  output logic                      handlerReq,
  output logic      [15:0]          handlerFile,
  input  wire logic                 handlerAck,
  input  wire logic                 handlerDone,
  // direct outputs
  output logic      [15:0]          outBits
);

  logic fnOnQ, cntOnQ, loadQ, hEnQ, lpmQ, hpmQ, ufmQ, ofmQ;
  logic spPrevQ, runQ, waitQ, execQ, missQ;
  logic lpiQ, hpiQ, ufiQ, ofiQ, ufQ, ofQ, mdQ;
  logic lpHitQ, hpHitQ, dirQ, cuQ, cdQ;
  logic [15:0] faultQ;
  logic [15:0] outQ;
  logic [15:0] hpoQ;
  logic [15:0] lpoQ;
  logic signed [31:0] accQ, accD, hipQ, lopQ, ovfQ, unfQ;
  hspc_pkg::hspc_cfg_t activeQ;
  hspc_pkg::hspc_step_t step;
  logic [31:0] rdD;
  logic [15:0] chk;
  logic wrCtrl, wrStat, wrAcc, spRise, runRise, loadEvt;
  logic lowModes, running, doUp, doDown;
  logic topWrap, botWrap, hpEvt, lpEvt, modeDone;
  logic irqLp, irqHp, irqUf, irqOf, anyIrq;

  // settings check, first failing test wins
  function automatic logic [15:0] checkCfg(
    input hspc_pkg::hspc_cfg_t c,
    input logic signed [31:0]  high_limit_value,
    input logic signed [31:0]  low_limit_value,
    input logic signed [31:0]  ovf);
    logic lowPreset;
    lowPreset = c.mode >= hspc_pkg::MODE_LOW_FIRST;
    if (c.handlerFile < hspc_pkg::PFN_MIN ||
        c.handlerFile > hspc_pkg::PFN_MAX)
      return hspc_pkg::FLT_FILE;
    if (c.mode > hspc_pkg::MODE_MAX)
      return hspc_pkg::FLT_MODE;
    if (lowPreset ? (high_limit_value <= low_limit_value) : (high_limit_value <= 32'sh0000_0000))
      return hspc_pkg::FLT_HIGH;
    if (high_limit_value > ovf)
      return hspc_pkg::FLT_OVF;
    return hspc_pkg::FLT_NONE;
  endfunction

  hspc_decoder #(
    .PINS   (hspc_pkg::NUM_PINS)
  ) u_dec (
    .clk    (clk),
    .rst    (rst),
    .pinIn  (countPins),
    .mode   (activeQ.mode[2:0]),
    .step   (step)
  );

  assign wrCtrl  = regWr && regAddr == hspc_pkg::ADDR_CTRL;
  assign wrStat  = regWr && regAddr == hspc_pkg::ADDR_STAT;
  assign wrAcc   = regWr && regAddr == hspc_pkg::ADDR_ACC;
  assign spRise  = loadQ & ~spPrevQ;
  assign runRise = controllerRun & ~runQ;
  assign loadEvt = spRise | runRise;
  assign chk     = checkCfg(cfgIn, hipQ, lopQ, ovfQ);
  assign lowModes = activeQ.mode >= hspc_pkg::MODE_LOW_FIRST;
  // counts on its own every cycle, no software pacing
  assign running = cntOnQ && controllerRun &&
                   faultQ == hspc_pkg::FLT_NONE;
  assign doUp    = running & step.up & ~step.hold;
  assign doDown  = running & step.down & ~step.hold;

  // control bits; counting enable and the rest reset cleared
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fnOnQ  <= 1'b0;
      cntOnQ <= 1'b0;
      loadQ  <= 1'b0;
      hEnQ   <= 1'b0;
      lpmQ   <= 1'b0;
      hpmQ   <= 1'b0;
      ufmQ   <= 1'b0;
      ofmQ   <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
      begin
        fnOnQ  <= regWdata[hspc_pkg::C_FE];
        cntOnQ <= regWdata[hspc_pkg::C_CE];
        loadQ  <= regWdata[hspc_pkg::C_SP];
        hEnQ   <= regWdata[hspc_pkg::C_UIE];
        lpmQ   <= regWdata[hspc_pkg::C_LPM];
        hpmQ   <= regWdata[hspc_pkg::C_HPM];
        ufmQ   <= regWdata[hspc_pkg::C_UFM];
        ofmQ   <= regWdata[hspc_pkg::C_OFM];
      end
      if (runRise && cfgIn.autoStart)
        fnOnQ <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      spPrevQ <= 1'b0;
      runQ    <= 1'b0;
    end
    else
    begin
      spPrevQ <= loadQ;
      runQ    <= controllerRun;
    end
  end

  // settings load; the accumulator is untouched so no count is lost
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      faultQ  <= hspc_pkg::FLT_NONE;
      activeQ <= '0;
    end
    else if (loadEvt)
    begin
      faultQ <= chk;
      if (chk == hspc_pkg::FLT_NONE)
        activeQ <= cfgIn;
    end
  end

  // presets and patterns stay writable while counting
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hipQ <= hspc_pkg::RST_HIP;
      lopQ <= hspc_pkg::RST_LOP;
      ovfQ <= hspc_pkg::RST_OVF;
      unfQ <= hspc_pkg::RST_UNF;
      hpoQ <= '0;
      lpoQ <= '0;
    end
    else if (regWr)
    begin
      case (regAddr)
        hspc_pkg::ADDR_HIP: hipQ <= regWdata;
        hspc_pkg::ADDR_LOP: lopQ <= regWdata;
        hspc_pkg::ADDR_OVF: ovfQ <= regWdata;
        hspc_pkg::ADDR_UNF: unfQ <= regWdata;
        hspc_pkg::ADDR_HPO: hpoQ <= regWdata[15:0];
        hspc_pkg::ADDR_LPO: lpoQ <= regWdata[15:0];
        default: hpoQ <= hpoQ;
      endcase
    end
  end

  // next count with wrap at the setpoints
  always_comb
  begin
    accD     = accQ;
    topWrap  = 1'b0;
    botWrap  = 1'b0;
    modeDone = 1'b0;
    if (running && step.zero)
      accD = 32'sh0000_0000;
    else if (doUp)
    begin
      if (accQ == ovfQ)
      begin
        accD    = unfQ;
        topWrap = 1'b1;
      end
      else
        accD = accQ + 32'sh0000_0001;
    end
    else if (doDown)
    begin
      if (accQ == unfQ)
      begin
        accD    = ovfQ;
        botWrap = lowModes;
      end
      else
        accD = accQ - 32'sh0000_0001;
    end
    hpEvt = (doUp | doDown) && !topWrap && !botWrap && accD == hipQ;
    lpEvt = lowModes && (doUp | doDown) && !topWrap && !botWrap &&
            accD == lopQ;
    // modes 0 and 1 restart from zero at the high preset
    if (hpEvt && !lowModes)
    begin
      modeDone = 1'b1;
      accD     = 32'sh0000_0000;
    end
  end

  // software write wins over a step in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      accQ <= 32'sh0000_0000;
    else if (wrAcc)
      accQ <= regWdata;
    else
      accQ <= accD;
  end

  // direction and reached flags follow the count
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dirQ   <= 1'b0;
      cuQ    <= 1'b0;
      cdQ    <= 1'b0;
      lpHitQ <= 1'b0;
      hpHitQ <= 1'b0;
    end
    else
    begin
      if (doUp | doDown)
      begin
        dirQ <= doDown;
        cuQ  <= doUp;
      end
      // cleared outside modes 2 to 7 so a stale down never lingers
      cdQ <= lowModes & ((doUp | doDown) ? doDown : cdQ);
      hpHitQ <= lowModes && accQ >= hipQ;
      lpHitQ <= lowModes && accQ <= lopQ;
    end
  end

  // limit switch outputs: patterns pass where the mask allows
  always_ff @(posedge clk)
  begin
    if (rst)
      outQ <= '0;
    else if (hpEvt)
      outQ <= (outQ & ~activeQ.outMask) |
              (hpoQ & activeQ.outMask);
    else if (lpEvt)
      outQ <= (outQ & ~activeQ.outMask) | (lpoQ & activeQ.outMask);
  end

  assign outBits = outQ;

  assign irqLp  = lpEvt & lpmQ;
  assign irqHp  = hpEvt & hpmQ;
  assign irqUf  = botWrap & ufmQ;
  assign irqOf  = topWrap & ofmQ;
  assign anyIrq = hEnQ && fnOnQ &&
                  (irqLp | irqHp | irqUf | irqOf);

  // handler handshake; a request while one is open is missed
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      waitQ <= 1'b0;
      execQ <= 1'b0;
    end
    else
    begin
      waitQ <= (waitQ & ~handlerAck) | (anyIrq & ~waitQ & ~execQ);
      execQ <= (execQ & ~handlerDone) | (handlerAck & waitQ);
    end
  end

  assign handlerReq  = waitQ;
  assign handlerFile = activeQ.handlerFile;

  // sticky status bits: hardware set wins over software write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      missQ <= 1'b0;
      lpiQ  <= 1'b0;
      hpiQ  <= 1'b0;
      ufiQ  <= 1'b0;
      ofiQ  <= 1'b0;
      ufQ   <= 1'b0;
      ofQ   <= 1'b0;
      mdQ   <= 1'b0;
    end
    else
    begin
      missQ <= (wrStat ? regWdata[hspc_pkg::S_UIL] : missQ) |
               (anyIrq & (waitQ | execQ));
      lpiQ <= (wrStat ? regWdata[hspc_pkg::S_LPI] : lpiQ) | irqLp;
      hpiQ <= (wrStat ? regWdata[hspc_pkg::S_HPI] : hpiQ) | irqHp;
      ufiQ <= (wrStat ? regWdata[hspc_pkg::S_UFI] : ufiQ) | irqUf;
      ofiQ <= (wrStat ? regWdata[hspc_pkg::S_OFI] : ofiQ) | irqOf;
      ufQ  <= (wrStat ? regWdata[hspc_pkg::S_UF] : ufQ) | botWrap;
      ofQ  <= (wrStat ? regWdata[hspc_pkg::S_OF] : ofQ) | topWrap;
      mdQ  <= (wrStat ? regWdata[hspc_pkg::S_MD] : mdQ) | modeDone;
    end
  end

  // read mux; live values, a read may see a count in motion
  always_comb
  begin
    rdD = '0;
    case (regAddr)
      hspc_pkg::ADDR_CTRL:
      begin
        rdD[hspc_pkg::C_FE]  = fnOnQ;
        rdD[hspc_pkg::C_CE]  = cntOnQ;
        rdD[hspc_pkg::C_SP]  = loadQ;
        rdD[hspc_pkg::C_UIE] = hEnQ;
        rdD[hspc_pkg::C_LPM] = lpmQ;
        rdD[hspc_pkg::C_HPM] = hpmQ;
        rdD[hspc_pkg::C_UFM] = ufmQ;
        rdD[hspc_pkg::C_OFM] = ofmQ;
        rdD[hspc_pkg::C_AS]  = activeQ.autoStart;
      end
      hspc_pkg::ADDR_STAT:
      begin
        rdD[hspc_pkg::S_UIX] = execQ;
        rdD[hspc_pkg::S_UIP] = waitQ;
        rdD[hspc_pkg::S_ED]  = faultQ != hspc_pkg::FLT_NONE;
        rdD[hspc_pkg::S_LPR] = lpHitQ;
        rdD[hspc_pkg::S_HPR] = hpHitQ;
        rdD[hspc_pkg::S_DIR] = dirQ;
        rdD[hspc_pkg::S_CD]  = cdQ;
        rdD[hspc_pkg::S_CU]  = cuQ;
        rdD[hspc_pkg::S_UIL] = missQ;
        rdD[hspc_pkg::S_LPI] = lpiQ;
        rdD[hspc_pkg::S_HPI] = hpiQ;
        rdD[hspc_pkg::S_UFI] = ufiQ;
        rdD[hspc_pkg::S_OFI] = ofiQ;
        rdD[hspc_pkg::S_UF]  = ufQ;
        rdD[hspc_pkg::S_OF]  = ofQ;
        rdD[hspc_pkg::S_MD]  = mdQ;
      end
      hspc_pkg::ADDR_FAULT: rdD[15:0] = faultQ;
      hspc_pkg::ADDR_PFN:   rdD[15:0] = activeQ.handlerFile;
      hspc_pkg::ADDR_MODE:  rdD[15:0] = activeQ.mode;
      hspc_pkg::ADDR_ACC:   rdD = accQ;
      hspc_pkg::ADDR_HIP:   rdD = hipQ;
      hspc_pkg::ADDR_LOP:   rdD = lopQ;
      hspc_pkg::ADDR_OVF:   rdD = ovfQ;
      hspc_pkg::ADDR_UNF:   rdD = unfQ;
      hspc_pkg::ADDR_OMB:   rdD[15:0] = activeQ.outMask;
      hspc_pkg::ADDR_HPO:   rdD[15:0] = hpoQ;
      hspc_pkg::ADDR_LPO:   rdD[15:0] = lpoQ;
      default:              rdD = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      regRdata <= '0;
    else if (regRd)
      regRdata <= rdD;
  end

  AST_HOLD_WHEN_OFF: assert property (@(posedge clk) disable iff (rst)
    !cntOnQ && !wrAcc |=> accQ == $past(accQ))
    else $error("count moved while counting disabled");

  AST_BAD_MODE: assert property (@(posedge clk) disable iff (rst)
    loadEvt && cfgIn.handlerFile >= hspc_pkg::PFN_MIN &&
    cfgIn.handlerFile <= hspc_pkg::PFN_MAX &&
    cfgIn.mode > hspc_pkg::MODE_MAX |=> faultQ == hspc_pkg::FLT_MODE)
    else $error("bad mode not reported as code 2");

  AST_IRQ_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (rst)
    $rose(waitQ) |-> $past(hEnQ) && $past(fnOnQ))
    else $error("handler requested without enable");

  AST_MISSED: assert property (@(posedge clk) disable iff (rst)
    anyIrq && execQ |=> missQ && !$rose(waitQ))
    else $error("request during handler not flagged missed");

  AST_LOW_ONLY_MODES: assert property (@(posedge clk) disable iff (rst)
    lpHitQ || cdQ |-> $past(activeQ.mode) >= hspc_pkg::MODE_LOW_FIRST)
    else $error("low flags set outside modes 2 to 7");

  AST_HIGH_OUTPUT: assert property (@(posedge clk) disable iff (rst)
    hpEvt |=> outBits == (($past(outQ) & ~$past(activeQ.outMask)) |
                          ($past(hpoQ) & $past(activeQ.outMask))))
    else $error("high preset pattern not driven next cycle");

  AST_TOP_WRAP: assert property (@(posedge clk) disable iff (rst)
    doUp && !wrAcc && !step.zero && accQ == ovfQ |=>
    accQ == $past(unfQ) && ofQ)
    else $error("overflow did not wrap to underflow value");

endmodule

// ==== hspc_pulse_src.sv ====
/*
  pulse source model for the four embedded count pins.
  assumes the counter samples pins on clk; idle pins sit low (pull-down).
*/
`timescale 1ns/1ps
module hspc_pulse_src
(
  // clock
  input  wire logic       clk,
  // embedded count pins
  output logic      [3:0] pins
);
  initial pins = 4'h0;

  // one pin pulses at a time; held 4 cycles so the synchroniser sees it
  task automatic pulse(input int n, input int ch);
    repeat (n)
    begin
      @(posedge clk);
      pins[ch] <= 1'b1;
      repeat (4) @(posedge clk);
      pins[ch] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
endmodule

// ==== hspc_tb_top.sv ====
/*
  self-checking bench of the pulse counter core.
  assumes the plain register port and the hspc_pulse_src model.
*/
`timescale 1ns/1ps
module hspc_tb_top;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } hspc_row_t;

  logic                clk;
  logic                rst;
  logic [7:0]          regAddr;
  logic [31:0]         regWdata;
  logic                regWr;
  logic                regRd;
  logic [31:0]         regRdata;
  logic [3:0]          countPins;
  logic                controllerRun;
  hspc_pkg::hspc_cfg_t cfgIn;
  logic                handlerReq;
  logic [15:0]         handlerFile;
  logic                handlerAck;
  logic                handlerDone;
  logic [15:0]         outBits;
  logic [31:0]         v;
  int                  error_cnt;
  int                  total_checks;

  hspc_row_t rows [17] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0},
    '{1'b0, 8'h04, 32'h0, 32'h0},
    '{1'b0, 8'h08, 32'h0, 32'h0},
    '{1'b0, 8'h14, 32'h0, 32'h0},
    '{1'b0, 8'h20, 32'h0, 32'h7FFFFFFF},
    '{1'b0, 8'h24, 32'h0, 32'h80000001},
    '{1'b0, 8'h40, 32'h0, 32'h0},
    '{1'b1, 8'h08, 32'hFFFF, 32'h0},
    '{1'b1, 8'h10, 32'h7, 32'h0},
    '{1'b1, 8'h28, 32'hFFFF, 32'h0},
    '{1'b1, 8'h0C, 32'h10, 32'h0},
    '{1'b1, 8'h04, 32'hFF, 32'h0},
    '{1'b1, 8'h18, 32'h3, 32'h3},
    '{1'b1, 8'h2C, 32'hA, 32'hA},
    '{1'b1, 8'h1C, 32'hFFFFFFFE, 32'hFFFFFFFE},
    '{1'b1, 8'h14, 32'h7, 32'h7},
    '{1'b1, 8'h40, 32'h5, 32'h0}
  };

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  hspc_top u_dut
  (
    .clk           (clk),
    .rst           (rst),
    .regAddr       (regAddr),
    .regWdata      (regWdata),
    .regWr         (regWr),
    .regRd         (regRd),
    .regRdata      (regRdata),
    .countPins     (countPins),
    .controllerRun (controllerRun),
    .cfgIn         (cfgIn),
    .handlerReq    (handlerReq),
    .handlerFile   (handlerFile),
    .handlerAck    (handlerAck),
    .handlerDone   (handlerDone),
    .outBits       (outBits)
  );

  hspc_pulse_src u_src
  (
    .clk  (clk),
    .pins (countPins)
  );

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic chk(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h", $time, m, g);
    end
  endtask

  task automatic strobe(input logic done);
    @(posedge clk);
    if (done)
      handlerDone <= 1'b1;
    else
      handlerAck <= 1'b1;
    @(posedge clk);
    handlerDone <= 1'b0;
    handlerAck <= 1'b0;
  endtask

  // settings load on a rising load-settings bit
  task automatic load(input logic [31:0] ctl);
    wr(8'h00, ctl & 32'hFFFFFFFB);
    wr(8'h00, ctl | 32'h4);
    repeat (3) @(posedge clk);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  initial
  begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    controllerRun = 1'b0;
    cfgIn = '{1'b0, 16'h000A, 16'h0000, 16'h000F};
    handlerAck = 1'b0;
    handlerDone = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e, "register row");
    end
    // run entry loads the stored settings
    wr(8'h14, 32'h0);
    @(posedge clk);
    controllerRun <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h08, v);
    chk(v, 32'h0, "fault after run");
    rd(8'h0C, v);
    chk(v, 32'h000A, "handler file");
    rd(8'h28, v);
    chk(v, 32'h000F, "output mask");
    wr(8'h00, 32'h2B);
    u_src.pulse(3, 0);
    @(negedge clk);
    chk({31'h0, handlerReq}, 32'h1, "request");
    chk({16'h0, handlerFile}, 32'h000A, "file out");
    chk({16'h0, outBits}, 32'h000A, "out bits");
    rd(8'h14, v);
    chk(v, 32'h0, "count after preset");
    rd(8'h04, v);
    chk({31'h0, v[15]}, 32'h1, "complete");
    // second event while the handler runs is missed
    strobe(1'b0);
    u_src.pulse(3, 0);
    rd(8'h04, v);
    chk({30'h0, v[8], v[0]}, 32'h3, "missed");
    strobe(1'b1);
    wr(8'h04, 32'h0);
    rd(8'h04, v);
    chk({30'h0, v[8], v[0]}, 32'h0, "cleared");
    // counting off holds the count
    wr(8'h00, 32'h29);
    u_src.pulse(2, 0);
    rd(8'h14, v);
    chk(v, 32'h0, "held count");
    wr(8'h00, 32'h23);
    u_src.pulse(3, 0);
    @(negedge clk);
    chk({31'h0, handlerReq}, 32'h0, "no request");
    u_src.pulse(1, 0);
    rd(8'h14, v);
    chk(v, 32'h1, "resumed count");
    // each fault code in turn
    for (int k = 1; k <= 4; k++)
    begin
      @(posedge clk);
      cfgIn.handlerFile <= (k == 1) ? 16'h0002 : 16'h000A;
      cfgIn.mode        <= (k == 2) ? 16'h0009 : 16'h0000;
      wr(8'h18, (k == 3) ? 32'h0 : ((k == 4) ? 32'h6 : 32'h3));
      wr(8'h20, (k == 4) ? 32'h5 : 32'h7FFFFFFF);
      load(32'h03);
      rd(8'h08, v);
      chk(v, k, "fault code");
      rd(8'h04, v);
      chk({31'h0, v[2]}, 32'h1, "fault flag");
    end
    // up/down mode: pin 0 counts up, pin 1 counts down
    @(posedge clk);
    cfgIn.mode <= 16'h0004;
    wr(8'h18, 32'h3);
    wr(8'h1C, 32'hFFFFFFFE);
    wr(8'h14, 32'h0);
    load(32'h03);
    rd(8'h04, v);
    chk({31'h0, v[2]}, 32'h0, "fault gone");
    u_src.pulse(1, 1);
    rd(8'h14, v);
    chk(v, 32'hFFFFFFFF, "down step");
    rd(8'h04, v);
    chk({30'h0, v[6:5]}, 32'h3, "down flags");
    // second step down lands on the low preset
    u_src.pulse(1, 1);
    @(negedge clk);
    chk({16'h0, outBits}, 32'h0, "low pattern");
    rd(8'h04, v);
    chk({31'h0, v[3]}, 32'h1, "low reached");
    // wrap through both setpoints, top value still 5
    wr(8'h14, 32'h5);
    u_src.pulse(1, 0);
    rd(8'h14, v);
    chk(v, 32'h80000001, "top wrap");
    u_src.pulse(1, 1);
    rd(8'h14, v);
    chk(v, 32'h5, "bottom wrap");
    rd(8'h04, v);
    chk({30'h0, v[14:13]}, 32'h3, "wrap flags");
    conclude();
  end
endmodule
